// ---- pwrseq_top.sv ----
// power mode, reset and clock output sequencer
`timescale 1ns/10ps
`default_nettype none
`include "pwrseq_params.svh"

module pwrseq_top
    import pwrseq_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic RESET_IN_N_I,
    input wire logic NMI_I,
    input wire logic INT_REQ_I,
    input wire logic IDLE_REQ_I,
    input wire logic PWRDN_REQ_I,
    input wire logic NMI_ACK_I,
    input wire logic PD_DELAY_PIN_I,
    input wire logic TEST_STRAP_PIN_I,
    output logic PD_DELAY_PIN_O,
    output logic PD_DELAY_PIN_OE_O,
    output logic TEST_STRAP_PULLUP_O,
    output logic CLOCK_OUT_PIN_O,
    output logic EXEC_CLK_EN_O,
    output logic BUS_CLK_EN_O,
    output logic PERIPH_CLK_EN_O,
    output logic OSC_EN_O,
    output logic REG_HOLD_O,
    output logic PIN_HOLD_O,
    output logic PIN_FLOAT_O,
    output logic BUS_ABORT_O,
    output logic RESET_OUT_O,
    output logic FETCH_START_O,
    output logic [19:0] FETCH_ADDR_O,
    output logic NMI_SERVICE_O,
    output logic [7:0] NMI_TYPE_O,
    output logic [2:0] MODE_O
);

    // minimum oscillator start-up wait, in input clock cycles
    localparam pwrseq_cnt_t PD_WAIT_CYC = pwrseq_cnt_t'(`PWRSEQ_PD_MIN_WAIT_CYC);

    // ================================================================
    // pin synchronisers
    logic reset_in_n;
    logic nmi_lvl;
    logic pd_pin_lvl;
    logic strap_lvl;

    pwrseq_sync #(.RESET_VAL(1'b0)) u_sync_reset (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .async_i(RESET_IN_N_I),
        .level_o(reset_in_n)
    );

    pwrseq_sync #(.RESET_VAL(1'b0)) u_sync_nmi (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .async_i(NMI_I),
        .level_o(nmi_lvl)
    );

    pwrseq_sync #(.RESET_VAL(1'b0)) u_sync_pd (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .async_i(PD_DELAY_PIN_I),
        .level_o(pd_pin_lvl)
    );

    pwrseq_sync #(.RESET_VAL(1'b1)) u_sync_strap (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .async_i(TEST_STRAP_PIN_I),
        .level_o(strap_lvl)
    );

    // ================================================================
    // state
    pwrseq_regs_s q;
    pwrseq_regs_s d;
    logic nmi_edge;
    logic in_reset;

    assign in_reset = !reset_in_n;
    assign nmi_edge = nmi_lvl && !q.nmi_prev;

    // ================================================================
    // next state
    always_comb begin
        d = q;
        d.fetch = 1'b0;
        d.nmi_svc = 1'b0;
        d.nmi_prev = nmi_lvl;
        // nmi edge wins over a same-cycle acknowledge
        if (nmi_edge) begin
            d.nmi_pend = 1'b1; // [RULE_17]
        end else if (NMI_ACK_I) begin
            d.nmi_pend = 1'b0;
        end
        // clock output toggles each input cycle, held low in powerdown and wake and from the second reset cycle
        if (q.mode == PWRSEQ_RESET) begin
            d.clk_out = 1'b0; // [RULE_13]
        end else if (q.mode == PWRSEQ_PWRDN || q.mode == PWRSEQ_WAKE) begin
            d.clk_out = 1'b0; // [RULE_04]
        end else begin
            d.clk_out = !q.clk_out; // [RULE_09]
        end
        case (q.mode)
            PWRSEQ_RESET: begin
                d.wait_cnt = '0;
                d.pd_drive = 1'b0;
                // strap is sampled every reset cycle, latched at release
                d.strap_low = !strap_lvl; // [RULE_14]
                if (!in_reset) begin
                    d.float_mode = q.strap_low; // [RULE_14]
                    d.mode = PWRSEQ_ACTIVE;
                    d.fetch = 1'b1; // [RULE_13]
                end
            end
            PWRSEQ_ACTIVE: begin
                // a pending nmi is served before any low-power request
                if (q.nmi_pend && !q.nmi_svc && !NMI_ACK_I) begin
                    d.nmi_svc = 1'b1; // [RULE_17]
                end else if (PWRDN_REQ_I) begin
                    d.mode = PWRSEQ_PWRDN; // [RULE_01]
                    d.pd_drive = 1'b1;
                end else if (IDLE_REQ_I) begin
                    d.mode = PWRSEQ_IDLE; // [RULE_01]
                end
            end
            PWRSEQ_IDLE: begin
                // any unmasked interrupt or nmi ends idle
                if (INT_REQ_I || nmi_edge || q.nmi_pend) begin
                    d.mode = PWRSEQ_ACTIVE; // [RULE_03] [RULE_18]
                end
            end
            PWRSEQ_PWRDN: begin
                // maskable interrupts are ignored here
                if (nmi_edge || q.nmi_pend) begin
                    d.mode = PWRSEQ_WAKE; // [RULE_06]
                    d.pd_drive = 1'b0;
                    d.wait_cnt = '0;
                end
            end
            PWRSEQ_WAKE: begin
                // released capacitor must decay low and minimum wait pass
                if (q.wait_cnt < PD_WAIT_CYC) begin
                    d.wait_cnt = q.wait_cnt + pwrseq_cnt_t'(1);
                end else if (!pd_pin_lvl) begin
                    d.mode = PWRSEQ_ACTIVE; // [RULE_07] [RULE_18]
                end
            end
            default: begin
                d.mode = PWRSEQ_RESET;
            end
        endcase
        // the clock output must sit at zero from the first powerdown cycle
        if (d.mode == PWRSEQ_PWRDN) begin
            d.clk_out = 1'b0; // [RULE_04]
        end
        // reset input overrides every mode
        if (in_reset) begin
            d.mode = PWRSEQ_RESET; // [RULE_11] [RULE_03]
            d.pd_drive = 1'b0;
            d.float_mode = 1'b0;
            d.nmi_svc = 1'b0;
            d.fetch = 1'b0;
        end
    end

    // ================================================================
    // registers
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            q <= '{
                mode: PWRSEQ_RESET,
                wait_cnt: '0,
                clk_out: 1'b0,
                nmi_prev: 1'b0,
                nmi_pend: 1'b0,
                nmi_svc: 1'b0,
                float_mode: 1'b0,
                strap_low: 1'b0,
                fetch: 1'b0,
                pd_drive: 1'b0
            };
        end else begin
            q <= d;
        end
    end

    // ================================================================
    // outputs
    logic active;
    logic frozen;

    assign active = (q.mode == PWRSEQ_ACTIVE);
    assign frozen = (q.mode == PWRSEQ_PWRDN) || (q.mode == PWRSEQ_WAKE);

    assign CLOCK_OUT_PIN_O = q.clk_out; // [RULE_09]
    assign EXEC_CLK_EN_O = active || (q.mode == PWRSEQ_RESET); // [RULE_02] [RULE_18]
    assign BUS_CLK_EN_O = active || (q.mode == PWRSEQ_RESET); // [RULE_02] [RULE_18]
    assign PERIPH_CLK_EN_O = !frozen; // [RULE_02] [RULE_04]
    assign OSC_EN_O = (q.mode != PWRSEQ_PWRDN); // [RULE_04] [RULE_15]
    assign REG_HOLD_O = frozen; // [RULE_05]
    assign PIN_HOLD_O = frozen; // [RULE_08]
    assign PIN_FLOAT_O = q.float_mode; // [RULE_15]
    assign BUS_ABORT_O = (q.mode == PWRSEQ_RESET); // [RULE_11]
    assign RESET_OUT_O = (q.mode == PWRSEQ_RESET); // [RULE_12]
    // weak pull during reset keeps the strap high unless held low from outside
    assign TEST_STRAP_PULLUP_O = (q.mode == PWRSEQ_RESET); // [RULE_14]
    // capacitor is charged high for the whole powerdown, except in float mode
    assign PD_DELAY_PIN_O = 1'b1;
    assign PD_DELAY_PIN_OE_O = q.pd_drive && !q.float_mode; // [RULE_07]
    assign FETCH_START_O = q.fetch; // [RULE_13]
    assign FETCH_ADDR_O = `PWRSEQ_RESET_VECTOR; // [RULE_13]
    assign NMI_SERVICE_O = q.nmi_svc; // [RULE_17]
    assign NMI_TYPE_O = `PWRSEQ_NMI_TYPE; // [RULE_17]
    assign MODE_O = q.mode; // [RULE_01]

endmodule

`default_nettype wire

// ---- pwrseq_params.svh ----
// constants for the power, reset and clock sequencer
// ====================================================================
// Notes on behaviour
// [RULE_01] three modes: active, idle, powerdown
// [RULE_02] idle stops execution and bus clocks only
// [RULE_03] idle ends on interrupt, nmi or reset
// [RULE_04] powerdown stops all clocks and oscillator
// [RULE_05] registers hold their contents during powerdown
// [RULE_06] only nmi or reset ends powerdown
// [RULE_07] wait on capacitor pin before resuming
// [RULE_08] pins keep state during powerdown
// [RULE_09] clock output is half input clock
// [RULE_10] external clock runs at twice core rate
// [RULE_11] reset aborts bus cycle, pins known
// [RULE_12] reset output follows reset input
// [RULE_13] reset release realigns clock, fetch FFFF0
// [RULE_14] strap low during reset selects float mode
// [RULE_15] float mode floats all pins but oscillator
// [RULE_16] upper address bits never pulled low in reset
// [RULE_17] nmi edge latched, serviced as type 2
// [RULE_18] any wake returns to active, clocks on
`ifndef PWRSEQ_PARAMS_SVH
`define PWRSEQ_PARAMS_SVH

// ====================================================================
// timing
`define PWRSEQ_CLK_PERIOD_NS 100
`define PWRSEQ_PD_MIN_WAIT_NS 1000
`define PWRSEQ_PD_MIN_WAIT_CYC ((`PWRSEQ_PD_MIN_WAIT_NS + `PWRSEQ_CLK_PERIOD_NS - 1) / `PWRSEQ_CLK_PERIOD_NS)

// ====================================================================
// fixed values
`define PWRSEQ_RESET_VECTOR 20'hFFFF0
`define PWRSEQ_NMI_TYPE 8'h02
`define PWRSEQ_CNT_W 8

`endif

// ---- pwrseq_pkg.sv ----
// types for the power, reset and clock sequencer
package pwrseq_pkg;

    typedef enum logic [2:0] {
        PWRSEQ_RESET,
        PWRSEQ_ACTIVE,
        PWRSEQ_IDLE,
        PWRSEQ_PWRDN,
        PWRSEQ_WAKE
    } pwrseq_mode_e;

    typedef logic [7:0] pwrseq_cnt_t;

    typedef struct packed {
        pwrseq_mode_e mode;
        pwrseq_cnt_t wait_cnt;
        logic clk_out;
        logic nmi_prev;
        logic nmi_pend;
        logic nmi_svc;
        logic float_mode;
        logic strap_low;
        logic fetch;
        logic pd_drive;
    } pwrseq_regs_s;

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
    } pwrseq_sync_s;

endpackage

// ---- pwrseq_sync.sv ----
// three-stage synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module pwrseq_sync
    import pwrseq_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o
);

    pwrseq_sync_s q;
    pwrseq_sync_s d;

    // ================================================================
    // next state
    always_comb begin
        d = q;
        d.ff1 = async_i;
        d.ff2 = q.ff1;
        d.ff3 = q.ff2;
        if (q.ff2 == q.ff3) begin
            d.level = q.ff3;
        end
    end

    // ================================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{ff1: RESET_VAL, ff2: RESET_VAL, ff3: RESET_VAL, level: RESET_VAL};
        end else begin
            q <= d;
        end
    end

    assign level_o = q.level;

endmodule

`default_nettype wire

// ---- pwrseq_top_monitor.sv ----
// port-level assertions for the sequencer
`timescale 1ns/10ps
`default_nettype none
module pwrseq_top_monitor (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic INT_REQ_I,
    input wire logic [2:0] MODE_O,
    input wire logic RESET_OUT_O,
    input wire logic BUS_ABORT_O,
    input wire logic EXEC_CLK_EN_O,
    input wire logic BUS_CLK_EN_O,
    input wire logic PERIPH_CLK_EN_O,
    input wire logic OSC_EN_O,
    input wire logic REG_HOLD_O,
    input wire logic PIN_HOLD_O,
    input wire logic CLOCK_OUT_PIN_O,
    input wire logic FETCH_START_O,
    input wire logic PIN_FLOAT_O,
    input wire logic PD_DELAY_PIN_OE_O,
    input wire logic NMI_SERVICE_O,
    input wire logic [7:0] NMI_TYPE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ==========
    // checks
    rst_out_a: assert property (MODE_O == 3'h0 |-> RESET_OUT_O && BUS_ABORT_O) else $error("reset out");
    idle_clk_a: assert property (MODE_O == 3'h2 |-> !EXEC_CLK_EN_O && !BUS_CLK_EN_O && PERIPH_CLK_EN_O)
        else $error("idle clocks");
    pd_clk_a: assert property (MODE_O == 3'h3 |-> !OSC_EN_O && !PERIPH_CLK_EN_O && !CLOCK_OUT_PIN_O
        && REG_HOLD_O && PIN_HOLD_O) else $error("powerdown state");
    pd_exit_a: assert property (MODE_O == 3'h3 |=> MODE_O inside {3'h0, 3'h3, 3'h4}) else $error("pd exit");
    idle_wake_a: assert property (MODE_O == 3'h2 && INT_REQ_I |=> MODE_O inside {3'h0, 3'h1}) else $error("idle");
    wake_wait_a: assert property ($rose(MODE_O == 3'h4) |-> (MODE_O != 3'h1)[*8]) else $error("wake wait");
    clk_half_a: assert property (MODE_O == 3'h1 && $past(MODE_O) == 3'h1 |-> CLOCK_OUT_PIN_O != $past(CLOCK_OUT_PIN_O))
        else $error("clock out");
    fetch_a: assert property ($fell(RESET_OUT_O) |-> FETCH_START_O ##1 !FETCH_START_O) else $error("fetch");
    float_a: assert property ($rose(PIN_FLOAT_O) |-> $past(RESET_OUT_O) && !PD_DELAY_PIN_OE_O) else $error("float");
    nmi_a: assert property (NMI_SERVICE_O |-> NMI_TYPE_O == 8'h02 && MODE_O == 3'h1) else $error("nmi");
    cover property (MODE_O == 3'h2 ##1 MODE_O == 3'h1);
    cover property (MODE_O == 3'h4 ##1 MODE_O == 3'h1);
    cover property (NMI_SERVICE_O);
endmodule
`default_nettype wire

// ---- pwrseq_partner.sv ----
// reset source, timing capacitor and strap pull for the sequencer
`timescale 1ns/10ps
`default_nettype none
module pwrseq_partner (
    input wire logic clk_i,
    input wire logic hold_i,
    input wire logic strap_low_i,
    input wire logic [7:0] cap_i,
    input wire logic pd_drv_i,
    input wire logic pd_oe_i,
    input wire logic pullup_i,
    output logic reset_in_n_o,
    output logic pd_pin_o,
    output var logic strap_o
);
    // ==========
    // capacitor charges while driven, then discharges
    logic [7:0] cap_q = 8'h00;
    initial strap_o = 1'b1;
    assign reset_in_n_o = !hold_i;
    assign pd_pin_o = (cap_q != 8'h00);
    always @(posedge clk_i) begin
        cap_q <= (pd_oe_i && pd_drv_i) ? cap_i : ((cap_q != 8'h00) ? cap_q - 8'h01 : 8'h00);
        // upper address bits are never pulled; unpulled strap wanders
        strap_o <= pullup_i ? !strap_low_i : !strap_o;
    end
endmodule
`default_nettype wire

// ---- power_reset_clock_sequencer_tb.sv ----
// self-checking bench for the sequencer
`timescale 1ns/10ps
`default_nettype none
module power_reset_clock_sequencer_tb;
    logic CLK_I, RST_I, RESET_IN_N_I, NMI_I, INT_REQ_I, IDLE_REQ_I, PWRDN_REQ_I, NMI_ACK_I, PD_DELAY_PIN_I;
    logic TEST_STRAP_PIN_I, PD_DELAY_PIN_O, PD_DELAY_PIN_OE_O, TEST_STRAP_PULLUP_O, CLOCK_OUT_PIN_O, EXEC_CLK_EN_O;
    logic BUS_CLK_EN_O, PERIPH_CLK_EN_O, OSC_EN_O, REG_HOLD_O, PIN_HOLD_O, PIN_FLOAT_O, BUS_ABORT_O, RESET_OUT_O;
    logic FETCH_START_O, NMI_SERVICE_O, hold, slow;
    logic [19:0] FETCH_ADDR_O;
    logic [7:0] NMI_TYPE_O, cap;
    logic [2:0] MODE_O;
    logic [31:0] seed = 32'h0000F0D9;
    logic [7:0] caps[2] = '{8'h02, 8'h1E};
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    time t0;
    pwrseq_top dut_u (.*);
    pwrseq_partner part_u (.clk_i(CLK_I), .hold_i(hold), .strap_low_i(slow), .cap_i(cap), .pd_drv_i(PD_DELAY_PIN_O),
        .pd_oe_i(PD_DELAY_PIN_OE_O), .pullup_i(TEST_STRAP_PULLUP_O), .reset_in_n_o(RESET_IN_N_I),
        .pd_pin_o(PD_DELAY_PIN_I), .strap_o(TEST_STRAP_PIN_I));
    // ==========
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic int minw(input int c);
        return (c > 10) ? c : 10;
    endfunction
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wm(input logic [2:0] m);
        int i;
        i = 0;
        while (MODE_O !== m && i < 80) begin
            @(negedge CLK_I);
            i++;
        end
        chk(MODE_O, m);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge CLK_I);
        s = 1'b0;
    endtask
    task automatic svc;
        int i;
        i = 0;
        while (NMI_SERVICE_O !== 1'b1 && i < 20) begin
            @(negedge CLK_I);
            i++;
        end
        chk(NMI_SERVICE_O, 1'b1);
        chk(NMI_TYPE_O, 8'h02);
        pulse(NMI_ACK_I);
        repeat (2) @(negedge CLK_I);
        repeat (6) begin
            @(negedge CLK_I);
            chk(NMI_SERVICE_O, 1'b0);
        end
    endtask
    task automatic stop_test;
        $display("errors=%0d checks=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        CLK_I = 1'b0;
        forever #50 CLK_I = ~CLK_I;
    end
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        {RST_I, hold, slow, NMI_I, INT_REQ_I, IDLE_REQ_I, PWRDN_REQ_I, NMI_ACK_I} = 8'hE0;
        cap = 8'h0F;
        repeat (20) @(negedge CLK_I);
        RST_I = 1'b0;
        repeat (4) @(negedge CLK_I);
        hold = 1'b0;
        wm(3'h1);
        chk(FETCH_START_O, 1'b1);
        chk(FETCH_ADDR_O, 20'hFFFF0);
        chk({PIN_FLOAT_O, PD_DELAY_PIN_OE_O}, 2'h2);
        {hold, slow} = 2'h2;
        wm(3'h0);
        chk({RESET_OUT_O, BUS_ABORT_O, TEST_STRAP_PULLUP_O}, 3'h7);
        repeat (5) @(negedge CLK_I);
        hold = 1'b0;
        wm(3'h1);
        chk(PIN_FLOAT_O, 1'b0);
        pulse(IDLE_REQ_I);
        wm(3'h2);
        chk({EXEC_CLK_EN_O, BUS_CLK_EN_O, PERIPH_CLK_EN_O}, 3'h1);
        INT_REQ_I = 1'b1;
        wm(3'h1);
        INT_REQ_I = 1'b0;
        chk(EXEC_CLK_EN_O, 1'b1);
        pulse(IDLE_REQ_I);
        wm(3'h2);
        NMI_I = 1'b1;
        wm(3'h1);
        NMI_I = 1'b0;
        svc();
        foreach (caps[k]) begin
            cap = caps[k];
            pulse(PWRDN_REQ_I);
            wm(3'h3);
            chk({OSC_EN_O, PERIPH_CLK_EN_O, CLOCK_OUT_PIN_O, REG_HOLD_O, PIN_HOLD_O, PD_DELAY_PIN_OE_O, PD_DELAY_PIN_O},
                7'h0F);
            INT_REQ_I = 1'b1;
            repeat (8) @(negedge CLK_I);
            chk(MODE_O, 3'h3);
            {INT_REQ_I, NMI_I} = 2'h1;
            wm(3'h4);
            t0 = $time;
            NMI_I = 1'b0;
            wm(3'h1);
            chk({EXEC_CLK_EN_O, BUS_CLK_EN_O, PERIPH_CLK_EN_O, OSC_EN_O}, 4'hF);
            chk(($time - t0) / 100 >= minw(cap), 1'b1);
            svc();
        end
        pulse(PWRDN_REQ_I);
        wm(3'h3);
        hold = 1'b1;
        wm(3'h0);
        hold = 1'b0;
        wm(3'h1);
        repeat (300) begin
            seed = xs(seed);
            {IDLE_REQ_I, PWRDN_REQ_I, INT_REQ_I, NMI_I, NMI_ACK_I} = {seed[0], &seed[2:1], seed[3], &seed[6:4], seed[7]};
            @(negedge CLK_I);
            chk(MODE_O <= 3'h4, 1'b1);
        end
        stop_test();
    end
endmodule
bind pwrseq_top pwrseq_top_monitor mon_u (.*);
`default_nettype wire
